// *** oss_source_select.sv ***
/*
  Oscillator source selection: system clock enable from divided fast RC or a
  slow source, crystal start-up, halt gating, peripheral and watchdog clocks,
  and crystal pin sharing. Registers on a plain strobe port.
  Assumes oscillator outputs and the crystal pins are asynchronous, HALT_IN
  comes from CPU logic on the core clock, and the downstream logic uses the
  enables as one-cycle clock-enable pulses on CORE_CLK_IN.
*/
`timescale 1ns/1ps

module oss_source_select #(
  parameter logic [oss_pkg::XTAL_CNT_W-1:0] XTAL_STARTUP_CYCLES =
    oss_pkg::XTAL_CNT_W'(oss_pkg::XTAL_STARTUP_CYC)
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  input wire logic [oss_pkg::ADDR_W-1:0] ADDR_IN,
  input wire logic [oss_pkg::DATA_W-1:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [oss_pkg::DATA_W-1:0] RDATA_OUT,
  input wire logic HALT_IN,
  input wire logic FAST_INTERNAL_RC_IN,
  input wire logic SLOW_INTERNAL_RC_IN,
  input wire logic SLOW_CRYSTAL_OSC_IN,
  output logic CRYSTAL_ENABLE_OUT,
  output logic FAST_RC_ENABLE_OUT,
  output logic SYS_CLK_EN_OUT,
  output logic FAST_PERIPH_EN_OUT,
  output logic TIMEBASE_EN_OUT,
  output logic WDT_CLK_EN_OUT,
  input wire logic CRYSTAL_PIN_A_IN,
  output logic CRYSTAL_PIN_A_OUT,
  output logic CRYSTAL_PIN_A_OE_OUT,
  input wire logic CRYSTAL_PIN_B_IN,
  output logic CRYSTAL_PIN_B_OUT,
  output logic CRYSTAL_PIN_B_OE_OUT,
  input wire logic GPIO_A_OUT_IN,
  input wire logic GPIO_A_OE_IN,
  output logic GPIO_A_IN_OUT,
  input wire logic GPIO_B_OUT_IN,
  input wire logic GPIO_B_OE_IN,
  output logic GPIO_B_IN_OUT
);

  localparam int NUM_SYNC = 5;
  localparam int SYNC_FAST = 0;
  localparam int SYNC_SLOW_RC = 1;
  localparam int SYNC_XTAL = 2;
  localparam int SYNC_PIN_A = 3;
  localparam int SYNC_PIN_B = 4;

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers for all asynchronous inputs
  wire [NUM_SYNC-1:0] async_w = {CRYSTAL_PIN_B_IN, CRYSTAL_PIN_A_IN, SLOW_CRYSTAL_OSC_IN,
                                 SLOW_INTERNAL_RC_IN, FAST_INTERNAL_RC_IN};
  logic [NUM_SYNC-1:0] level_w;
  logic [NUM_SYNC-1:0] rise_w;

  generate
    for (genvar i = 0; i < NUM_SYNC; i++) begin : g_sync
      oss_sync u_sync (
        .clk_in(CORE_CLK_IN),
        .rst_in(RST_IN),
        .ce_in(CE_IN),
        .async_in(async_w[i]),
        .level_out(level_w[i]),
        .rise_out(rise_w[i])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [oss_pkg::DATA_W-1:0] clk_ctrl_r;
  logic xtal_en_r;
  logic pin_xtal_r;
  logic [oss_pkg::DATA_W-1:0] rdata_r;

  wire wr_clk_ctrl = WR_IN && (ADDR_IN == oss_pkg::REG_CLK_CTRL);
  wire wr_xtal_ctrl = WR_IN && (ADDR_IN == oss_pkg::REG_XTAL_CTRL);
  wire wr_pin_share = WR_IN && (ADDR_IN == oss_pkg::REG_PIN_SHARE);

  wire [2:0] sel_w = clk_ctrl_r[oss_pkg::SEL_HI:oss_pkg::SEL_LO];
  wire slow_sel_w = clk_ctrl_r[oss_pkg::SLOW_SEL_BIT];
  wire fast_idle_w = clk_ctrl_r[oss_pkg::FAST_IDLE_BIT];
  wire slow_idle_w = clk_ctrl_r[oss_pkg::SLOW_IDLE_BIT];

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      clk_ctrl_r <= oss_pkg::CLK_CTRL_RST;
      xtal_en_r <= oss_pkg::RST_OFF;
      pin_xtal_r <= oss_pkg::RST_OFF;
    end else if (CE_IN) begin
      if (wr_clk_ctrl) begin
        clk_ctrl_r <= WDATA_IN & oss_pkg::CLK_CTRL_WMASK;
      end
      if (wr_xtal_ctrl) begin
        xtal_en_r <= WDATA_IN[oss_pkg::XTAL_EN_BIT];
      end
      if (wr_pin_share) begin
        pin_xtal_r <= WDATA_IN[oss_pkg::PIN_XTAL_BIT];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Crystal start-up
  oss_pkg::oss_xtal_state_t xtal_state_r;
  oss_pkg::oss_xtal_state_t xtal_state_nxt;
  logic [oss_pkg::XTAL_CNT_W-1:0] xtal_cnt_r;

  // The crystal runs only while it also owns its pins
  wire xtal_run_w = xtal_en_r && pin_xtal_r;
  wire xtal_done_w = (xtal_cnt_r == XTAL_STARTUP_CYCLES - 20'h00001);
  wire xtal_ready_w = (xtal_state_r == oss_pkg::OSS_XTAL_READY);

  always_comb begin
    xtal_state_nxt = xtal_state_r;
    case (xtal_state_r)
      oss_pkg::OSS_XTAL_OFF: begin
        if (xtal_run_w) begin
          xtal_state_nxt = oss_pkg::OSS_XTAL_STARTING;
        end
      end
      oss_pkg::OSS_XTAL_STARTING: begin
        if (!xtal_run_w) begin
          xtal_state_nxt = oss_pkg::OSS_XTAL_OFF;
        end else if (xtal_done_w) begin
          xtal_state_nxt = oss_pkg::OSS_XTAL_READY;
        end
      end
      oss_pkg::OSS_XTAL_READY: begin
        if (!xtal_run_w) begin
          xtal_state_nxt = oss_pkg::OSS_XTAL_OFF;
        end
      end
      default: begin
        xtal_state_nxt = oss_pkg::OSS_XTAL_OFF;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      xtal_state_r <= oss_pkg::OSS_XTAL_OFF;
      xtal_cnt_r <= '0;
    end else if (CE_IN) begin
      xtal_state_r <= xtal_state_nxt;
      if (xtal_state_r == oss_pkg::OSS_XTAL_STARTING) begin
        xtal_cnt_r <= xtal_cnt_r + 20'h00001;
      end else begin
        xtal_cnt_r <= '0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Source selection
  wire fast_tick_w = rise_w[SYNC_FAST];
  wire slow_rc_tick_w = rise_w[SYNC_SLOW_RC];
  // Crystal edges before start-up ends are not trusted
  wire xtal_tick_w = rise_w[SYNC_XTAL] & xtal_ready_w;
  wire slow_tick_w = slow_sel_w ? xtal_tick_w : slow_rc_tick_w;

  logic active_slow_r;
  logic div_tick_w;
  wire want_slow_w = (sel_w == oss_pkg::SEL_SLOW);
  wire sys_tick_w = active_slow_r ? slow_tick_w : div_tick_w;
  // Divider restarts as the fast source is taken back, giving a full first period
  wire to_fast_w = active_slow_r && !want_slow_w && sys_tick_w;

  oss_divider u_divider (
    .clk_in(CORE_CLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .tick_in(fast_tick_w),
    .restart_in(to_fast_w),
    .ratio_in(sel_w),
    .tick_out(div_tick_w)
  );

  // Swap sources only at the end of a period of the current one
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      active_slow_r <= 1'b0;
    end else if (CE_IN && sys_tick_w) begin
      active_slow_r <= want_slow_w;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Gating and output enables
  logic sys_en_r;
  logic fast_periph_r;
  logic timebase_r;
  logic wdt_r;
  wire fast_on_w = !HALT_IN || fast_idle_w;
  wire slow_on_w = !HALT_IN || slow_idle_w;

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      sys_en_r <= 1'b0;
      fast_periph_r <= 1'b0;
      timebase_r <= 1'b0;
      wdt_r <= 1'b0;
    end else if (CE_IN) begin
      sys_en_r <= sys_tick_w && !HALT_IN;
      fast_periph_r <= fast_tick_w && fast_on_w;
      timebase_r <= slow_tick_w && slow_on_w;
      wdt_r <= slow_rc_tick_w;
    end
  end

  assign SYS_CLK_EN_OUT = sys_en_r;
  assign FAST_PERIPH_EN_OUT = fast_periph_r;
  assign TIMEBASE_EN_OUT = timebase_r;
  assign WDT_CLK_EN_OUT = wdt_r;
  assign FAST_RC_ENABLE_OUT = fast_on_w || !active_slow_r;
  assign CRYSTAL_ENABLE_OUT = xtal_run_w;

  //////////////////////////////////////////////////////////////////////////////
  // Crystal pin sharing: pins are released to I/O unless the crystal runs
  wire xtal_owns_w = xtal_run_w;
  assign CRYSTAL_PIN_A_OUT = GPIO_A_OUT_IN;
  assign CRYSTAL_PIN_B_OUT = GPIO_B_OUT_IN;
  assign CRYSTAL_PIN_A_OE_OUT = GPIO_A_OE_IN && !xtal_owns_w;
  assign CRYSTAL_PIN_B_OE_OUT = GPIO_B_OE_IN && !xtal_owns_w;
  assign GPIO_A_IN_OUT = level_w[SYNC_PIN_A] && !xtal_owns_w;
  assign GPIO_B_IN_OUT = level_w[SYNC_PIN_B] && !xtal_owns_w;

  //////////////////////////////////////////////////////////////////////////////
  // Read path
  logic [oss_pkg::DATA_W-1:0] rd_mux_w;
  always_comb begin
    rd_mux_w = '0;
    if (ADDR_IN == oss_pkg::REG_CLK_CTRL) begin
      rd_mux_w = clk_ctrl_r;
    end else if (ADDR_IN == oss_pkg::REG_XTAL_CTRL) begin
      rd_mux_w[oss_pkg::XTAL_EN_BIT] = xtal_en_r;
      rd_mux_w[oss_pkg::XTAL_RDY_BIT] = xtal_ready_w;
    end else if (ADDR_IN == oss_pkg::REG_PIN_SHARE) begin
      rd_mux_w[oss_pkg::PIN_XTAL_BIT] = pin_xtal_r;
    end else if (ADDR_IN == oss_pkg::REG_STATUS) begin
      rd_mux_w[oss_pkg::STAT_SLOW_BIT] = active_slow_r;
      rd_mux_w[oss_pkg::STAT_HALT_BIT] = HALT_IN;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      rdata_r <= '0;
    end else if (CE_IN) begin
      rdata_r <= RD_IN ? rd_mux_w : '0;
    end
  end
  assign RDATA_OUT = rdata_r;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_halt_gates;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (CE_IN && HALT_IN) |=> !SYS_CLK_EN_OUT;
  endproperty
  a_halt_gates: assert property (p_halt_gates)
    else $error("system clock enable while halted");

  property p_xtal_unready;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (CE_IN && active_slow_r && slow_sel_w && !xtal_ready_w) |=> !SYS_CLK_EN_OUT;
  endproperty
  a_xtal_unready: assert property (p_xtal_unready)
    else $error("crystal used before start-up ended");

  property p_xtal_wait;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    $rose(xtal_ready_w) |-> $past(xtal_cnt_r) == XTAL_STARTUP_CYCLES - 20'h00001;
  endproperty
  a_xtal_wait: assert property (p_xtal_wait)
    else $error("crystal ready without full start-up wait");

  property p_pins_owned;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    xtal_owns_w |-> !CRYSTAL_PIN_A_OE_OUT && !CRYSTAL_PIN_B_OE_OUT && !GPIO_A_IN_OUT;
  endproperty
  a_pins_owned: assert property (p_pins_owned)
    else $error("crystal pins driven while crystal runs");

  property p_pins_free;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    !xtal_en_r |-> (CRYSTAL_PIN_A_OE_OUT == GPIO_A_OE_IN) && (CRYSTAL_PIN_B_OE_OUT == GPIO_B_OE_IN);
  endproperty
  a_pins_free: assert property (p_pins_free)
    else $error("crystal pins not free for I/O");

  property p_wdt_clock;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (CE_IN && slow_rc_tick_w) |=> WDT_CLK_EN_OUT;
  endproperty
  a_wdt_clock: assert property (p_wdt_clock)
    else $error("watchdog missed a slow RC edge");

  property p_swap_boundary;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (active_slow_r != $past(active_slow_r)) |-> $past(sys_tick_w) && $past(CE_IN);
  endproperty
  a_swap_boundary: assert property (p_swap_boundary)
    else $error("source swapped mid period");

  property p_slow_rc_path;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (CE_IN && active_slow_r && !slow_sel_w && slow_rc_tick_w && !HALT_IN) |=> SYS_CLK_EN_OUT;
  endproperty
  a_slow_rc_path: assert property (p_slow_rc_path)
    else $error("slow RC edge did not clock the system");

  property p_fast_freq;
    @(posedge CORE_CLK_IN) oss_pkg::FAST_RC_MHZ inside {4, 8, 12};
  endproperty
  a_fast_freq: assert property (p_fast_freq)
    else $error("fast RC frequency not a legal setting");

  c_xtal_ready: cover property (@(posedge CORE_CLK_IN) disable iff (RST_IN) $rose(xtal_ready_w));
  c_to_slow: cover property (@(posedge CORE_CLK_IN) disable iff (RST_IN) $rose(active_slow_r));
  c_to_fast: cover property (@(posedge CORE_CLK_IN) disable iff (RST_IN) to_fast_w);
  c_idle_fast: cover property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    HALT_IN && FAST_PERIPH_EN_OUT);

endmodule // oss_source_select

// *** oss_pkg.sv ***
/*
  Constants, register map and types for the oscillator source selection block.
  Assumes a single 100 MHz core clock and oscillator outputs that arrive as
  free-running square waves from analog cells outside the core clock domain.
*/
// Notes on behaviour
// - System clock picks fast or slow source by three-bit select, changeable live.
// - Slow clock comes from slow internal RC or the crystal, per select bit.
// - Fast internal RC frequency is a build constant: 4, 8 or 12 MHz.
// - Writing crystal enable starts it if the pin-share bit is set; unusable until start-up delay elapses.
// - Sleep or idle gates the system clock; timers can keep their own clock.
// - Oscillators also clock the watchdog and the time-base logic.
// - Pin-share bit gives crystal pins to the crystal or to general I/O; the crystal gets them only while crystal enable is also set.
// - Slow internal RC runs at nominal 32 kHz, needing no external parts.
// - Crystal runs at a fixed nominal 32.768 kHz when chosen as slow source.
// - Select codes 000 to 110 give fast divided by 1 to 64; 111 slow.
// - Slow select zero picks slow internal RC, one picks the crystal.

package oss_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register bus
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] REG_CLK_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_XTAL_CTRL = 4'h1;
  localparam logic [ADDR_W-1:0] REG_PIN_SHARE = 4'h2;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h3;

  // Clock control fields
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 5;
  localparam int SLOW_SEL_BIT = 2;
  localparam int FAST_IDLE_BIT = 1;
  localparam int SLOW_IDLE_BIT = 0;
  localparam logic [DATA_W-1:0] CLK_CTRL_WMASK = 8'he7;
  localparam logic [DATA_W-1:0] CLK_CTRL_RST = 8'h00;
  localparam logic [2:0] SEL_SLOW = 3'h7;

  // Crystal control, pin share and status fields
  localparam int XTAL_EN_BIT = 0;
  localparam int XTAL_RDY_BIT = 1;
  localparam int PIN_XTAL_BIT = 0;
  localparam int STAT_SLOW_BIT = 0;
  localparam int STAT_HALT_BIT = 1;
  localparam logic RST_OFF = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // Oscillator figures
  localparam int CORE_CLK_MHZ = 100;
  localparam int FAST_RC_MHZ = 12;
  localparam int SLOW_RC_HZ = 32000;
  localparam int CRYSTAL_HZ = 32768;

  // Crystal start-up wait; the length is not fixed by the oscillator cell
  localparam int XTAL_STARTUP_US = 1000;
  localparam int XTAL_STARTUP_CYC = XTAL_STARTUP_US * CORE_CLK_MHZ;
  localparam int XTAL_CNT_W = 20;

  // Divider: ratio is a power of two up to 64
  localparam int DIV_W = 6;
  localparam logic [DIV_W-1:0] DIV_MAX = 6'h3f;
  localparam logic [2:0] DIV_SHIFT_TOP = 3'h6;

  typedef enum logic [1:0] {
    OSS_XTAL_OFF,
    OSS_XTAL_STARTING,
    OSS_XTAL_READY
  } oss_xtal_state_t;

endpackage

// *** oss_sync.sv ***
/*
  Two-flop synchroniser with rising-edge pulse for one asynchronous level.
  Assumes the input toggles slower than half the core clock rate.
*/
`timescale 1ns/1ps

module oss_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic async_in,
  output logic level_out,
  output logic rise_out
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // Only sync_r reads meta_r
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else if (ce_in) begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_out = sync_r;
  assign rise_out = sync_r & ~prev_r;

endmodule // oss_sync

// *** oss_divider.sv ***
/*
  Power-of-two divider of a tick stream, ratio 1 to 64.
  Assumes tick_in is a one-cycle pulse per fast oscillator period.
*/
`timescale 1ns/1ps

module oss_divider (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic tick_in,
  input wire logic restart_in,
  input wire logic [2:0] ratio_in,
  output logic tick_out
);

  logic [oss_pkg::DIV_W-1:0] cnt_r;
  logic [oss_pkg::DIV_W-1:0] limit_r;
  wire [2:0] shift_w = oss_pkg::DIV_SHIFT_TOP - ratio_in;
  wire [oss_pkg::DIV_W-1:0] limit_nxt = oss_pkg::DIV_MAX >> shift_w;

  assign tick_out = tick_in & (cnt_r == limit_r);

  // A new ratio is taken only at a period boundary, so no period is cut short
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_r <= '0;
      limit_r <= '0;
    end else if (ce_in) begin
      if (restart_in || tick_out) begin
        cnt_r <= '0;
        limit_r <= limit_nxt;
      end else if (tick_in) begin
        cnt_r <= cnt_r + 6'h01;
      end
    end
  end

  property p_div_new_period;
    @(posedge clk_in) disable iff (rst_in)
    (ce_in && tick_out && !restart_in) |=> (cnt_r == '0) && (limit_r == $past(limit_nxt));
  endproperty
  a_div_new_period: assert property (p_div_new_period)
    else $error("divider did not start a fresh period");

endmodule // oss_divider

// *** oss_source_select_tb_top.sv ***
/*
  Self-checking bench for the oscillator source selection block.
  Assumes oss_pkg and the design files are compiled first. The bench plays the
  register master, the three oscillators, the CPU halt line and the GPIO logic.
*/
`timescale 1ns/1ps

module oss_source_select_tb_top;

  ////////////////////////////////////////////////////////////////////////////////
  // Stimulus and design
  localparam int XTAL_CYC = 20;
  logic CORE_CLK_IN = 1'b0;
  logic RST_IN = 1'b1;
  logic CE_IN = 1'b1;
  logic [oss_pkg::ADDR_W-1:0] ADDR_IN = 4'h0;
  logic [oss_pkg::DATA_W-1:0] WDATA_IN = 8'h00;
  logic WR_IN = 1'b0;
  logic RD_IN = 1'b0;
  logic HALT_IN = 1'b0;
  logic fast_rc = 1'b0;
  logic slow_rc = 1'b0;
  logic xt_r = 1'b0;
  logic pin_a = 1'b0;
  logic pin_b = 1'b0;
  logic ga_out = 1'b0;
  logic ga_oe = 1'b0;
  logic gb_out = 1'b0;
  logic gb_oe = 1'b0;
  logic [oss_pkg::DATA_W-1:0] RDATA_OUT;
  logic xt_en, frc_en, sys_en, fp_en, tb_en, wdt_en;
  logic pa_out, pa_oe, pb_out, pb_oe, ga_in, gb_in;
  int err_total = 0;
  int checks = 0;
  int cnt [0:6] = '{default: 0};
  int base [0:6];
  int dlt [0:6];
  logic [2:0] osc_d = 3'h0;
  logic rd_d = 1'b0;
  logic [7:0] exp_q [$];

  oss_source_select #(.XTAL_STARTUP_CYCLES(20'h00014)) oss_source_select_inst (
    .CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .CE_IN(CE_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
    .HALT_IN(HALT_IN), .FAST_INTERNAL_RC_IN(fast_rc), .SLOW_INTERNAL_RC_IN(slow_rc),
    .SLOW_CRYSTAL_OSC_IN(xt_r), .CRYSTAL_ENABLE_OUT(xt_en), .FAST_RC_ENABLE_OUT(frc_en),
    .SYS_CLK_EN_OUT(sys_en), .FAST_PERIPH_EN_OUT(fp_en), .TIMEBASE_EN_OUT(tb_en),
    .WDT_CLK_EN_OUT(wdt_en), .CRYSTAL_PIN_A_IN(pin_a), .CRYSTAL_PIN_A_OUT(pa_out),
    .CRYSTAL_PIN_A_OE_OUT(pa_oe), .CRYSTAL_PIN_B_IN(pin_b), .CRYSTAL_PIN_B_OUT(pb_out),
    .CRYSTAL_PIN_B_OE_OUT(pb_oe), .GPIO_A_OUT_IN(ga_out), .GPIO_A_OE_IN(ga_oe),
    .GPIO_A_IN_OUT(ga_in), .GPIO_B_OUT_IN(gb_out), .GPIO_B_OE_IN(gb_oe),
    .GPIO_B_IN_OUT(gb_in));

  initial begin
    forever #5 CORE_CLK_IN = ~CORE_CLK_IN;
  end

  // Oscillator edges are offset by 2 ns so they never meet a core clock edge
  initial begin
    #2;
    forever #40 fast_rc = ~fast_rc;
  end
  initial begin
    #2;
    forever #800 slow_rc = ~slow_rc;
  end
  // The crystal stands low unless the block enables it
  initial begin
    #2;
    forever #1000 xt_r = xt_en & ~xt_r;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks and counters
  task automatic test_done();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rng(input int got, input int lo, input int hi, input string what);
    checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("[ERR] %0t %s count %0d outside %0d..%0d", $time, what, got, lo, hi);
    end
  endtask

  // Counts bench oscillator edges (0..2) and design enable pulses (3..6)
  always @(posedge CORE_CLK_IN) begin
    osc_d <= {xt_r, slow_rc, fast_rc};
    if (fast_rc && !osc_d[0]) cnt[0]++;
    if (slow_rc && !osc_d[1]) cnt[1]++;
    if (xt_r && !osc_d[2]) cnt[2]++;
    if (sys_en === 1'b1) cnt[3]++;
    if (fp_en === 1'b1) cnt[4]++;
    if (tb_en === 1'b1) cnt[5]++;
    if (wdt_en === 1'b1) cnt[6]++;
  end

  // Read data stands only in the cycle after the strobe, zero otherwise
  always @(posedge CORE_CLK_IN) begin
    rd_d <= RD_IN;
    if (rd_d) chk(RDATA_OUT, exp_q.pop_front(), "read data");
    else if (!RST_IN) chk(RDATA_OUT, 8'h00, "idle read data");
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CORE_CLK_IN);
    WR_IN <= 1'b1;
    ADDR_IN <= a;
    WDATA_IN <= d;
    @(posedge CORE_CLK_IN);
    WR_IN <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge CORE_CLK_IN);
    RD_IN <= 1'b1;
    ADDR_IN <= a;
    exp_q.push_back(e);
    @(posedge CORE_CLK_IN);
    RD_IN <= 1'b0;
  endtask

  // Waits for k edges of one source, bounded, and records every counter's change
  task automatic win(input int src, input int k);
    int lim;
    lim = 0;
    base = cnt;
    while (cnt[src] < base[src] + k && lim < k * 400) begin
      @(posedge CORE_CLK_IN);
      lim++;
    end
    if (lim >= k * 400) begin
      err_total++;
      $display("[ERR] %0t oscillator wait ran out", $time);
      test_done();
    end
    for (int i = 0; i < 7; i++) dlt[i] = cnt[i] - base[i];
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  initial begin
    #1000000;
    err_total++;
    $display("[ERR] %0t run limit reached", $time);
    test_done();
  end

  initial begin
    void'($urandom(13));
    repeat (16) @(posedge CORE_CLK_IN);
    RST_IN <= 1'b0;
    rd(oss_pkg::REG_CLK_CTRL, oss_pkg::CLK_CTRL_RST);
    rd(oss_pkg::REG_XTAL_CTRL, 8'h00);
    rd(oss_pkg::REG_PIN_SHARE, 8'h00);
    rd(oss_pkg::REG_STATUS, 8'h00);
    wr(4'h9, 8'($urandom));
    rd(4'h9, 8'h00);
    // A write while the clock enable is low must be dropped
    CE_IN <= 1'b0;
    wr(oss_pkg::REG_CLK_CTRL, 8'he0);
    CE_IN <= 1'b1;
    rd(oss_pkg::REG_CLK_CTRL, oss_pkg::CLK_CTRL_RST);
    // Every fast ratio, switched live; bits 4:3 are written but read back as 0
    for (int n = 0; n < 7; n++) begin
      wr(oss_pkg::REG_CLK_CTRL, {3'(n), 5'h1b});
      rd(oss_pkg::REG_CLK_CTRL, {3'(n), 5'h1b} & oss_pkg::CLK_CTRL_WMASK);
      win(0, 130);
      win(0, 128);
      rng(dlt[3], (128 >> n) - 1, (128 >> n) + 1, "divided system rate");
      rng(dlt[4], 127, 129, "fast peripheral rate");
    end
    chk({7'h0, frc_en}, 8'h01, "fast rc running");
    // Slow internal RC as system clock
    wr(oss_pkg::REG_CLK_CTRL, 8'he0);
    win(1, 4);
    rd(oss_pkg::REG_STATUS, 8'h01);
    win(1, 8);
    rng(dlt[3], 7, 9, "slow rc system rate");
    rng(dlt[6], 7, 9, "watchdog rate");
    rng(dlt[5], 7, 9, "time base rate");
    // Crystal start-up, pins taken by the crystal; its edges are masked until ready
    ga_oe <= 1'b1;
    gb_oe <= 1'b1;
    pin_a <= 1'b1;
    pin_b <= 1'b1;
    wr(oss_pkg::REG_PIN_SHARE, 8'h01);
    wr(oss_pkg::REG_CLK_CTRL, 8'he4);
    wr(oss_pkg::REG_XTAL_CTRL, 8'h01);
    rd(oss_pkg::REG_XTAL_CTRL, 8'h01);
    base = cnt;
    repeat (XTAL_CYC - 4) @(posedge CORE_CLK_IN);
    rng(cnt[3] - base[3], 0, 0, "system clock before crystal ready");
    repeat (8) @(posedge CORE_CLK_IN);
    rd(oss_pkg::REG_XTAL_CTRL, 8'h03);
    chk({7'h0, xt_en}, 8'h01, "crystal enable");
    chk({4'h0, pa_oe, pb_oe, ga_in, gb_in}, 8'h00, "pin held by crystal");
    win(2, 4);
    win(2, 8);
    rng(dlt[3], 7, 9, "crystal system rate");
    rng(dlt[5], 7, 9, "crystal time base rate");
    rng(dlt[6], 9, 11, "watchdog stays on slow rc");
    // Back to fast, crystal off, pins free for random GPIO traffic
    wr(oss_pkg::REG_CLK_CTRL, 8'h00);
    win(2, 2);
    wr(oss_pkg::REG_XTAL_CTRL, 8'h00);
    rd(oss_pkg::REG_XTAL_CTRL, 8'h00);
    wr(oss_pkg::REG_PIN_SHARE, 8'h00);
    for (int i = 0; i < 8; i++) begin
      @(posedge CORE_CLK_IN);
      ga_out <= 1'($urandom);
      ga_oe <= 1'($urandom);
      gb_out <= 1'($urandom);
      gb_oe <= 1'($urandom);
      pin_a <= 1'($urandom);
      pin_b <= 1'($urandom);
      repeat (4) @(posedge CORE_CLK_IN);
      chk({4'h0, pa_oe, pa_out, pb_oe, pb_out}, {4'h0, ga_oe, ga_out, gb_oe, gb_out}, "pin drive");
      chk({6'h0, ga_in, gb_in}, {6'h0, pin_a, pin_b}, "pin input");
    end
    // Halt: system clock stops, watchdog keeps running, idle bits keep peripherals
    @(posedge CORE_CLK_IN);
    HALT_IN <= 1'b1;
    rd(oss_pkg::REG_STATUS, 8'h02);
    win(1, 8);
    rng(dlt[3], 0, 0, "system clock in halt");
    rng(dlt[4] + dlt[5], 0, 0, "peripherals in sleep");
    rng(dlt[6], 7, 9, "watchdog in halt");
    wr(oss_pkg::REG_CLK_CTRL, 8'h03);
    win(1, 2);
    win(1, 8);
    rng(dlt[3], 0, 0, "system clock in idle");
    rng(dlt[4], 158, 162, "fast peripheral in idle");
    rng(dlt[5], 7, 9, "time base in idle");
    wr(oss_pkg::REG_CLK_CTRL, 8'he0);
    win(1, 4);
    chk({7'h0, frc_en}, 8'h00, "fast rc stopped in slow halt");
    HALT_IN <= 1'b0;
    win(1, 4);
    rng(dlt[3], 3, 5, "system clock after wake");
    test_done();
  end

endmodule // oss_source_select_tb_top
